/* File: hdl/ecib_keystream.sv */
`timescale 1ns/100ps
`include "ecib_defines.svh"

// keyed forward permutation of one counter block
module ecib_keystream
    import ecib_pkg::*;
(
    input wire logic [127:0] counter_block,
    input wire logic [127:0] key,
    output logic [127:0] keystream
);

    // one mixing round on four 32-bit lanes
    function automatic logic [127:0] ecib_round(input logic [127:0] x, input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        a = x[127:96] ^ k[127:96];
        b = x[95:64] ^ k[95:64];
        c = x[63:32] ^ k[63:32];
        d = x[31:0] ^ k[31:0] ^ {24'h00_0000, rc};
        a = a + b;
        d = {d[15:0], d[31:16]} ^ a;
        c = c + d;
        b = {b[19:0], b[31:20]} ^ c;
        a = a + b;
        d = {d[23:0], d[31:24]} ^ a;
        c = c + d;
        b = {b[24:0], b[31:25]} ^ c;
        return {b, c, d, a};
    endfunction

    // forward direction only, used for both encrypt and decrypt
    always_comb
    begin
        keystream = counter_block;
        for (int r = 0; r < `ECIB_ROUNDS; r++)
        begin
            keystream = ecib_round(keystream, {key[127 - r*8 -: 8], key[119:0]} ^ key, 8'(r + 1));
        end
        keystream = keystream ^ key;
    end

endmodule // ecib_keystream

/* File: hdl/ecib_top.sv */
`timescale 1ns/100ps
`include "ecib_defines.svh"

// Overview of operation
// - encrypt by xoring forward cipher output of each counter with plaintext
// - decrypt also uses the forward cipher, xored with ciphertext
// - first counter of each envelope payload is the vector built for it
// - each later counter of the same envelope is previous counter plus one
// - odd length: last eq uses upper 64 keystream bits, lower discarded
// - keystream masked per byte so control characters pass through unchanged
// - keystream may be computed ahead once the counter is known
// - receiver vector and counters equal those used by the transmitter
// - counters unique under one key through distinct vectors per envelope
// - transmit vector computed when a start header is seen on transmit
// - receive vector computed when a start header is seen on receive
// - vector built from header contents and the channel index
// - top vector bit gives direction, next seven bits the channel
// - address field holds the encrypting side's station address
// - subscriber decrypt uses the central terminal address it learned
// - central terminal decrypt looks up address from the header link id
// - timestamp latches the cipher clock when the start header is seen
// - cipher clock steps with the mpcp clock but is its own counter
// - block number cleared at header, plus one per later counter block
// - cipher block is 128 bits carrying two 64-bit eqs
// - headers and inter-envelope characters bypass the cipher
// - cipher clock is a 48-bit counter
module ecib_top
    import ecib_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cipher_enable,
    input wire logic path_is_rx,
    input wire logic is_central_terminal,
    input wire logic [6:0] channel_number,
    input wire logic [47:0] own_station_address,
    input wire logic [47:0] learned_station_address,
    input wire logic tbl_write,
    input wire logic [3:0] tbl_index,
    input wire logic [47:0] tbl_address,
    input wire logic mpcp_tick,
    input wire logic cipher_clock_load,
    input wire logic [47:0] cipher_clock_value,
    input wire logic [127:0] key_in,
    input wire logic in_valid,
    input wire ecib_kind_t in_kind,
    input wire logic [63:0] in_data,
    input wire logic [7:0] in_ctrl_mask,
    input wire logic [15:0] in_llid,
    output logic out_valid,
    output ecib_kind_t out_kind,
    output logic [63:0] out_data,
    output logic [127:0] counter_block_out,
    output logic [47:0] cipher_clock_out
);

    ////////////////////////////////////////////////////////////////////////////
    // cipher clock

    logic [47:0] cipher_clk_ff;
    logic [47:0] nxt_cipher_clk;

    // own 48-bit counter, stepped by the mpcp tick enable
    always_comb
    begin
        nxt_cipher_clk = cipher_clk_ff;
        if (cipher_clock_load)
        begin
            nxt_cipher_clk = cipher_clock_value;
        end
        else if (mpcp_tick)
        begin
            nxt_cipher_clk = cipher_clk_ff + 48'h0000_0000_0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cipher_clk_ff <= `ECIB_CLK_RST;
        end
        else
        begin
            cipher_clk_ff <= nxt_cipher_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link id to station address table

    logic [47:0] addr_tbl_ff [`ECIB_TBL_DEPTH];
    logic [47:0] nxt_addr_tbl [`ECIB_TBL_DEPTH];
    logic [47:0] table_station_address;

    // flop storage written from the management side
    always_comb
    begin
        nxt_addr_tbl = addr_tbl_ff;
        if (tbl_write)
        begin
            nxt_addr_tbl[tbl_index] = tbl_address;
        end
        table_station_address = addr_tbl_ff[in_llid[`ECIB_TBL_IDX_W-1:0]];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `ECIB_TBL_DEPTH; i++)
            begin
                addr_tbl_ff[i] <= `ECIB_ADDR_RST;
            end
        end
        else
        begin
            addr_tbl_ff <= nxt_addr_tbl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vector builder

    logic [127:0] built_vector;

    // header context and channel in, vector out
    ecib_vector_builder u_vector_builder (
        .is_central_terminal(is_central_terminal),
        .path_is_rx(path_is_rx),
        .channel_number(channel_number),
        .own_station_address(own_station_address),
        .learned_station_address(learned_station_address),
        .table_station_address(table_station_address),
        .header_timestamp_field(cipher_clk_ff),
        .initial_counter_vector(built_vector)
    );

    ////////////////////////////////////////////////////////////////////////////
    // message tracking: counter, half select, key

    ecib_state_t state_ff;
    ecib_state_t nxt_state;
    logic [127:0] counter_ff;
    logic [127:0] nxt_counter;
    logic half_ff;
    logic nxt_half;
    logic [127:0] key_ff;
    logic [127:0] nxt_key;
    logic is_header;
    logic is_payload;

    assign is_header = in_valid && (in_kind == ecib_kind_header);
    assign is_payload = in_valid && (in_kind == ecib_kind_payload);

    // header loads vector and key, payload words walk the counter
    always_comb
    begin
        nxt_state = state_ff;
        nxt_counter = counter_ff;
        nxt_half = half_ff;
        nxt_key = key_ff;
        unique case (state_ff)
            ecib_st_idle:
            begin
                if (is_header)
                begin
                    nxt_state = ecib_st_payload;
                end
            end
            ecib_st_payload:
            begin
                if (is_payload)
                begin
                    nxt_half = ~half_ff;
                    if (half_ff)
                    begin
                        nxt_counter = counter_ff + 128'h1;
                    end
                end
            end
            default:
            begin
                nxt_state = ecib_st_idle;
            end
        endcase
        if (is_header)
        begin
            nxt_counter = built_vector;
            nxt_half = 1'h0;
            nxt_key = key_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_ff <= ecib_st_idle;
            counter_ff <= `ECIB_VEC_RST;
            half_ff <= 1'h0;
            key_ff <= `ECIB_KEY_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            counter_ff <= nxt_counter;
            half_ff <= nxt_half;
            key_ff <= nxt_key;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // keystream, ready before the payload word arrives

    logic [127:0] keystream;

    // forward cipher on the live counter
    ecib_keystream u_keystream (
        .counter_block(counter_ff),
        .key(key_ff),
        .keystream(keystream)
    );

    ////////////////////////////////////////////////////////////////////////////
    // stage one: capture word and its keystream half

    logic s1_valid_ff;
    logic nxt_s1_valid;
    ecib_kind_t s1_kind_ff;
    ecib_kind_t nxt_s1_kind;
    logic [63:0] s1_data_ff;
    logic [63:0] nxt_s1_data;
    logic [63:0] s1_ks_ff;
    logic [63:0] nxt_s1_ks;
    logic s1_cipher_ff;
    logic nxt_s1_cipher;

    // expand per-byte control flags into a keep mask
    function automatic logic [63:0] ecib_byte_keep(input logic [7:0] ctrl);
        logic [63:0] m;
        m = 64'h0;
        for (int b = 0; b < 8; b++)
        begin
            m[b*8 +: 8] = ctrl[b] ? 8'h00 : 8'hff;
        end
        return m;
    endfunction

    // pick upper half first, lower half second
    always_comb
    begin
        nxt_s1_valid = in_valid;
        nxt_s1_kind = in_kind;
        nxt_s1_data = in_data;
        nxt_s1_ks = half_ff ? keystream[63:0] : keystream[127:64];
        nxt_s1_ks = nxt_s1_ks & ecib_byte_keep(in_ctrl_mask);
        nxt_s1_cipher = is_payload && cipher_enable && (state_ff == ecib_st_payload);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_valid_ff <= 1'h0;
            s1_kind_ff <= ecib_kind_other;
            s1_data_ff <= 64'h0;
            s1_ks_ff <= 64'h0;
            s1_cipher_ff <= 1'h0;
        end
        else
        begin
            s1_valid_ff <= nxt_s1_valid;
            s1_kind_ff <= nxt_s1_kind;
            s1_data_ff <= nxt_s1_data;
            s1_ks_ff <= nxt_s1_ks;
            s1_cipher_ff <= nxt_s1_cipher;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stage two: xor or pass, same depth either way

    logic out_valid_ff;
    logic nxt_out_valid;
    ecib_kind_t out_kind_ff;
    ecib_kind_t nxt_out_kind;
    logic [63:0] out_data_ff;
    logic [63:0] nxt_out_data;
    logic [127:0] counter_out_ff;
    logic [47:0] clock_out_ff;

    // bypass words and disabled mode pass unchanged
    always_comb
    begin
        nxt_out_valid = s1_valid_ff;
        nxt_out_kind = s1_kind_ff;
        nxt_out_data = s1_data_ff;
        if (s1_cipher_ff)
        begin
            nxt_out_data = s1_data_ff ^ s1_ks_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            out_valid_ff <= 1'h0;
            out_kind_ff <= ecib_kind_other;
            out_data_ff <= 64'h0;
            counter_out_ff <= `ECIB_VEC_RST;
            clock_out_ff <= `ECIB_CLK_RST;
        end
        else
        begin
            out_valid_ff <= nxt_out_valid;
            out_kind_ff <= nxt_out_kind;
            out_data_ff <= nxt_out_data;
            counter_out_ff <= counter_ff;
            clock_out_ff <= cipher_clk_ff;
        end
    end

    // outputs straight from flops
    assign out_valid = out_valid_ff;
    assign out_kind = out_kind_ff;
    assign out_data = out_data_ff;
    assign counter_block_out = counter_out_ff;
    assign cipher_clock_out = clock_out_ff;

endmodule // ecib_top

/* File: hdl/ecib_vector_builder.sv */
`timescale 1ns/100ps
`include "ecib_defines.svh"

// builds the initial counter vector from header context
module ecib_vector_builder
    import ecib_pkg::*;
(
    input wire logic is_central_terminal,
    input wire logic path_is_rx,
    input wire logic [6:0] channel_number,
    input wire logic [47:0] own_station_address,
    input wire logic [47:0] learned_station_address,
    input wire logic [47:0] table_station_address,
    input wire logic [47:0] header_timestamp_field,
    output logic [127:0] initial_counter_vector
);

    logic lane_dir;
    logic [47:0] source_station_address;

    // direction: central terminal sends down, subscriber sends up
    always_comb
    begin
        lane_dir = is_central_terminal ? path_is_rx : ~path_is_rx;
        if (!path_is_rx)
        begin
            source_station_address = own_station_address;
        end
        else if (is_central_terminal)
        begin
            source_station_address = table_station_address;
        end
        else
        begin
            source_station_address = learned_station_address;
        end
    end

    // field packing, block number starts at zero
    always_comb
    begin
        initial_counter_vector = `ECIB_VEC_RST;
        initial_counter_vector[`ECIB_DIR_BIT] = lane_dir;
        initial_counter_vector[`ECIB_CHAN_HI:`ECIB_CHAN_LO] = channel_number;
        initial_counter_vector[`ECIB_ADDR_HI:`ECIB_ADDR_LO] = source_station_address;
        initial_counter_vector[`ECIB_TS_HI:`ECIB_TS_LO] = header_timestamp_field;
        initial_counter_vector[`ECIB_IDX_HI:`ECIB_IDX_LO] = 24'h00_0000;
    end

endmodule // ecib_vector_builder

/* File: inc/ecib_defines.svh */
`ifndef ECIB_DEFINES_SVH
`define ECIB_DEFINES_SVH

// vector field positions, most significant first
`define ECIB_DIR_BIT 127
`define ECIB_CHAN_HI 126
`define ECIB_CHAN_LO 120
`define ECIB_ADDR_HI 119
`define ECIB_ADDR_LO 72
`define ECIB_TS_HI 71
`define ECIB_TS_LO 24
`define ECIB_IDX_HI 23
`define ECIB_IDX_LO 0

// widths
`define ECIB_BLK_W 128
`define ECIB_EQ_W 64
`define ECIB_ADDR_W 48
`define ECIB_CLK_W 48
`define ECIB_TBL_IDX_W 4
`define ECIB_TBL_DEPTH 16

// reset values
`define ECIB_CLK_RST 48'h0000_0000_0000
`define ECIB_VEC_RST 128'h0
`define ECIB_KEY_RST 128'h0
`define ECIB_ADDR_RST 48'h0000_0000_0000

// direction codes in the top vector bit
`define ECIB_DIR_DOWN 1'h0
`define ECIB_DIR_UP 1'h1

// timing: keystream rounds and fixed pipeline depth in cycles
`define ECIB_ROUNDS 4
`define ECIB_LATENCY 2

`endif

/* File: inc/ecib_pkg.sv */
package ecib_pkg;

    // kind of each eq word on the stream
    typedef enum logic [1:0] {
        ecib_kind_payload = 2'h0,
        ecib_kind_header = 2'h1,
        ecib_kind_bypass = 2'h2,
        ecib_kind_other = 2'h3
    } ecib_kind_t;

    // message tracking, gray along idle -> payload
    typedef enum logic [1:0] {
        ecib_st_idle = 2'h0,
        ecib_st_payload = 2'h1
    } ecib_state_t;

endpackage

/* File: verification/ecib_link_sink.sv */
`timescale 1ns/100ps
// reconciliation side: takes each delivered word
module ecib_link_sink
    import ecib_pkg::*;
(
    input wire logic clk,
    input wire logic clear,
    input wire logic out_valid,
    input wire ecib_kind_t out_kind,
    input wire logic [63:0] out_data
);
    logic [63:0] words [0:15];
    logic [3:0] count = 4'h0;

    // store words in arrival order, no stall
    always @(posedge clk)
    begin
        if (clear)
        begin
            count <= 4'h0;
        end
        else if (out_valid)
        begin
            words[count] <= out_data;
            count <= count + 4'h1;
        end
    end
endmodule // ecib_link_sink

/* File: verification/ecib_top_checker.sv */
`timescale 1ns/100ps
module ecib_top_checker
    import ecib_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cipher_enable,
    input wire logic path_is_rx,
    input wire logic is_central_terminal,
    input wire logic [6:0] channel_number,
    input wire logic mpcp_tick,
    input wire logic cipher_clock_load,
    input wire logic [47:0] cipher_clock_value,
    input wire logic in_valid,
    input wire ecib_kind_t in_kind,
    input wire logic [63:0] in_data,
    input wire logic [7:0] in_ctrl_mask,
    input wire logic out_valid,
    input wire ecib_kind_t out_kind,
    input wire logic [63:0] out_data,
    input wire logic [127:0] counter_block_out,
    input wire logic [47:0] cipher_clock_out
);
    logic [63:0] cmask;
    logic hdr;
    logic calm;

    // header strobe and a clock with no load or tick
    assign hdr = in_valid && (in_kind == ecib_kind_header);
    assign calm = !mpcp_tick && !cipher_clock_load;

    // control bytes widened to bit mask
    always_comb
    begin
        for (int b = 0; b < 8; b++)
        begin
            cmask[8 * b +: 8] = {8{in_ctrl_mask[b]}};
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_valid_latency: assert property (out_valid == $past(in_valid, 2))
        else $error("output valid not two cycles after input");
    a_kind_follows: assert property (out_valid |-> out_kind == $past(in_kind, 2))
        else $error("output kind differs from input kind");
    a_plain_pass: assert property (out_valid && !$past(cipher_enable, 2) |-> out_data == $past(in_data, 2))
        else $error("disabled word changed");
    a_bypass_clear: assert property (out_valid && $past(in_kind, 2) != ecib_kind_payload
        |-> out_data == $past(in_data, 2))
        else $error("non payload word changed");
    a_ctrl_kept: assert property (out_valid |-> ((out_data ^ $past(in_data, 2)) & $past(cmask, 2)) == 64'h0)
        else $error("control byte changed");
    a_clock_load: assert property (cipher_clock_load |-> ##2 cipher_clock_out == $past(cipher_clock_value, 2))
        else $error("cipher clock load lost");
    a_clock_step: assert property (mpcp_tick && !cipher_clock_load
        |-> ##2 cipher_clock_out == $past(cipher_clock_out) + 48'h1)
        else $error("cipher clock did not step");
    a_index_zero: assert property (hdr |-> ##2 counter_block_out[23:0] == 24'h0)
        else $error("block number not cleared at header");
    a_lane_field: assert property (hdr |-> ##2 counter_block_out[127:120]
        == $past({is_central_terminal ~^ path_is_rx, channel_number}, 2))
        else $error("lane field wrong");
    a_time_field: assert property (hdr && calm && $past(calm)
        |-> ##2 counter_block_out[71:24] == $past(cipher_clock_out, 2))
        else $error("timestamp field wrong");

    c_header: cover property (hdr);
    c_cipher: cover property (out_valid && $past(cipher_enable, 2) && $past(in_kind, 2) == ecib_kind_payload);
    c_load: cover property (cipher_clock_load && mpcp_tick);
endmodule // ecib_top_checker

bind ecib_top ecib_top_checker i_chk (
    .clk, .rst_b, .cipher_enable, .path_is_rx, .is_central_terminal, .channel_number, .mpcp_tick,
    .cipher_clock_load, .cipher_clock_value, .in_valid, .in_kind, .in_data, .in_ctrl_mask,
    .out_valid, .out_kind, .out_data, .counter_block_out, .cipher_clock_out
);

/* File: verification/envelope_ctr_cipher_iv_builder_test.sv */
`timescale 1ns/100ps
module envelope_ctr_cipher_iv_builder_test
    import ecib_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, cipher_enable = 1'b0, path_is_rx = 1'b0, is_central_terminal = 1'b0;
    logic tbl_write = 1'b0, mpcp_tick = 1'b0, cipher_clock_load = 1'b0, in_valid = 1'b0, sink_clear = 1'b0;
    logic [6:0] channel_number = 7'h00;
    logic [47:0] own_station_address = 48'h0, learned_station_address = 48'h0, tbl_address = 48'h0;
    logic [47:0] cipher_clock_value = 48'h0, ts, addr;
    logic [3:0] tbl_index = 4'h0;
    logic [127:0] key_in = 128'h0, counter_block_out;
    ecib_kind_t in_kind = ecib_kind_other, out_kind;
    logic [63:0] in_data = 64'h0, out_data;
    logic [7:0] in_ctrl_mask = 8'h00;
    logic [15:0] in_llid = 16'h0;
    logic out_valid;
    logic [47:0] cipher_clock_out;
    logic [63:0] pt [0:7], ct [0:7];
    logic [7:0] cm [0:7];
    int err_count = 0, tests_run = 0, k;

    ecib_top i_dut (.clk, .rst_b, .cipher_enable, .path_is_rx, .is_central_terminal, .channel_number,
        .own_station_address, .learned_station_address, .tbl_write, .tbl_index, .tbl_address, .mpcp_tick,
        .cipher_clock_load, .cipher_clock_value, .key_in, .in_valid, .in_kind, .in_data, .in_ctrl_mask,
        .in_llid, .out_valid, .out_kind, .out_data, .counter_block_out, .cipher_clock_out);
    ecib_link_sink i_sink (.clk, .clear(sink_clear), .out_valid, .out_kind, .out_data);

    initial
    begin
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // bench model of the vector layout
    function automatic logic [127:0] vec(input logic d, input logic [47:0] a);
        return {d, channel_number, a, ts, 24'h000000};
    endfunction

    // header then np payload words, counter checked on the way
    task automatic env(input int np, input logic en, input logic use_ct, input logic [127:0] v);
        for (int i = 0; i <= np + 2; i++)
        begin
            @(posedge clk);
            in_valid <= (i <= np + 1);
            in_kind <= (i == 0) ? ecib_kind_header : (i == np + 1) ? ecib_kind_bypass : ecib_kind_payload;
            in_data <= use_ct ? ct[i] : pt[i];
            in_ctrl_mask <= cm[i];
            sink_clear <= (i == 0);
            cipher_enable <= en;
            #1;
            if (i == 2) chk("counter", v, counter_block_out);
            if (i == 4) chk("counter_next", v + 128'h1, counter_block_out);
        end
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hd8876fb5));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk("clock_rst", 48'h0, cipher_clock_out);
        chk("counter_rst", 128'h0, counter_block_out);
        // load beside a tick, then k ticks
        ts = 48'({$urandom, $urandom});
        k = 1 + $urandom % 20;
        @(posedge clk);
        cipher_clock_value <= ts;
        cipher_clock_load <= 1'b1;
        mpcp_tick <= 1'b1;
        key_in <= {$urandom, $urandom, $urandom, $urandom};
        in_llid <= 16'($urandom);
        @(posedge clk);
        cipher_clock_load <= 1'b0;
        repeat (k) @(posedge clk);
        mpcp_tick <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        ts = ts + 48'(k);
        chk("clock_count", ts, cipher_clock_out);
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                pt[i] = {$urandom, $urandom};
                ct[i] = pt[i];
                cm[i] = (i == 0) ? 8'h00 : 8'($urandom) & 8'h0f;
            end
            addr = 48'({$urandom, $urandom});
            // encrypting role
            @(posedge clk);
            channel_number <= 7'($urandom);
            is_central_terminal <= (p == 0);
            path_is_rx <= 1'b0;
            own_station_address <= addr;
            learned_station_address <= ~addr;
            tbl_write <= 1'b1;
            tbl_index <= in_llid[3:0];
            tbl_address <= addr;
            @(posedge clk);
            tbl_write <= 1'b0;
            @(posedge clk);
            env(5, 1'b1, 1'b0, vec(p[0], addr));
            chk("header", pt[0], i_sink.words[0]);
            chk("bypass", pt[6], i_sink.words[6]);
            for (int i = 1; i < 6; i++)
            begin
                ct[i] = i_sink.words[i];
                chk("ciphered", 1'b1, ct[i][63:32] !== pt[i][63:32]);
            end
            // decrypting role with matched vector
            is_central_terminal <= (p != 0);
            path_is_rx <= 1'b1;
            own_station_address <= ~addr;
            learned_station_address <= p ? ~addr : addr;
            @(posedge clk);
            env(5, 1'b1, 1'b1, vec(p[0], addr));
            for (int i = 0; i < 7; i++) chk("plain", pt[i], i_sink.words[i]);
            env(3, 1'b0, 1'b0, vec(p[0], addr));
            for (int i = 0; i < 5; i++) chk("disabled", pt[i], i_sink.words[i]);
        end
        // second reset in mid run
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk("clock_rst2", 48'h0, cipher_clock_out);
        chk("counter_rst2", 128'h0, counter_block_out);
        // payload before any header passes unciphered
        @(posedge clk);
        cipher_enable <= 1'b1;
        in_valid <= 1'b1;
        in_kind <= ecib_kind_payload;
        in_data <= pt[1];
        in_ctrl_mask <= 8'h00;
        @(posedge clk);
        in_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk("idle_pass", {1'b1, ecib_kind_payload, pt[1]}, {out_valid, out_kind, out_data});
        give_verdict();
    end
endmodule // envelope_ctr_cipher_iv_builder_test
